// ===== add_and_shift_bitclear_exec.sv
// Execution datapath for pointer add, sums, masks, shift and bit clear
`default_nettype none
module add_and_shift_bitclear_exec #(
    parameter int DATA_W = exec_pkg::DATA_W,
    parameter int PTR_W = exec_pkg::PTR_W
) (
    // Clock and reset
    input wire logic clk,
    input wire logic reset,
    // Decoded instruction from the core
    input wire logic instr_valid,
    input wire logic [exec_pkg::OPC_W-1:0] opcode,
    // Operand read back from the addressed file register
    input wire logic [DATA_W-1:0] file_rdata,
    // File register write request
    output exec_pkg::file_wr_t file_wr,
    // Architectural state
    output logic [DATA_W-1:0] accum,
    output exec_pkg::flags_t flags,
    output logic [PTR_W-1:0] indirect_pointer_0,
    output logic [PTR_W-1:0] indirect_pointer_1
);
    exec_pkg::op_t op;
    logic dest_file;
    logic [exec_pkg::ADDR_W-1:0] faddr;
    logic [2:0] bit_idx;
    logic [DATA_W-1:0] lit;
    logic [PTR_W-1:0] ptr_lit;
    logic [DATA_W-1:0] add_b;
    logic add_cin;
    logic [DATA_W-1:0] add_sum;
    logic add_cout;
    logic add_half;
    logic [DATA_W-1:0] result;
    logic write_acc;
    logic write_file;

    logic [DATA_W-1:0] acc_r, acc_nxt;
    exec_pkg::flags_t flags_r, flags_nxt;
    logic [PTR_W-1:0] ptr0_r, ptr0_nxt;
    logic [PTR_W-1:0] ptr1_r, ptr1_nxt;
    exec_pkg::file_wr_t wr_r, wr_nxt;

    // Zero test shared by every flag-setting path
    function automatic logic is_zero(input logic [DATA_W-1:0] v);
        return v == '0;
    endfunction

    // Opcode decode; anything unknown is a no-op for this slice
    always_comb begin
        op = exec_pkg::OP_NONE;
        if (instr_valid) begin
            if (opcode[13:exec_pkg::TOP7_LSB] == exec_pkg::OPC_PTR_ADD)
                op = exec_pkg::OP_PTR_ADD;
            else if (opcode[13:exec_pkg::TOP6_LSB] == exec_pkg::OPC_IMM_SUM)
                op = exec_pkg::OP_IMM_SUM;
            else if (opcode[13:exec_pkg::TOP6_LSB] == exec_pkg::OPC_IMM_MASK)
                op = exec_pkg::OP_IMM_MASK;
            else if (opcode[13:exec_pkg::TOP6_LSB] == exec_pkg::OPC_FILE_SUM)
                op = exec_pkg::OP_FILE_SUM;
            else if (opcode[13:exec_pkg::TOP6_LSB]
                     == exec_pkg::OPC_FILE_SUM_C)
                op = exec_pkg::OP_FILE_SUM_C;
            else if (opcode[13:exec_pkg::TOP6_LSB]
                     == exec_pkg::OPC_FILE_MASK)
                op = exec_pkg::OP_FILE_MASK;
            else if (opcode[13:exec_pkg::TOP6_LSB] == exec_pkg::OPC_SHIFT)
                op = exec_pkg::OP_SHIFT;
            else if (opcode[13:exec_pkg::TOP4_LSB] == exec_pkg::OPC_BIT_CLR)
                op = exec_pkg::OP_BIT_CLR;
        end
    end

    // Operand fields
    assign dest_file = opcode[exec_pkg::DEST_BIT];
    assign faddr = opcode[exec_pkg::ADDR_W-1:0];
    assign bit_idx = opcode[exec_pkg::BIT_IDX_LSB+2:exec_pkg::BIT_IDX_LSB];
    assign lit = opcode[DATA_W-1:0];
    // Sign extension of the 6-bit pointer literal
    assign ptr_lit = {{(PTR_W-exec_pkg::PTR_LIT_W)
                       {opcode[exec_pkg::PTR_LIT_W-1]}},
                      opcode[exec_pkg::PTR_LIT_W-1:0]};

    // Adder operand select; carry-in only for the carry form
    always_comb begin
        add_b = (op == exec_pkg::OP_IMM_SUM) ? lit : file_rdata;
        add_cin = (op == exec_pkg::OP_FILE_SUM_C) ? flags_r.carry
                                                  : 1'b0;
    end

    exec_adder #(.WIDTH(DATA_W)) exec_adder_i (
        .a(acc_r),
        .b(add_b),
        .cin(add_cin),
        .sum(add_sum),
        .cout(add_cout),
        .half(add_half)
    );

    // Result, destination and flag updates
    always_comb begin
        result = '0;
        write_acc = 1'b0;
        write_file = 1'b0;
        flags_nxt = flags_r;
        ptr0_nxt = ptr0_r;
        ptr1_nxt = ptr1_r;
        case (op)
            exec_pkg::OP_PTR_ADD: begin
                // Modulo-16-bit wrap falls out of the width
                if (opcode[exec_pkg::PTR_SEL_BIT])
                    ptr1_nxt = ptr1_r + ptr_lit;
                else
                    ptr0_nxt = ptr0_r + ptr_lit;
            end
            exec_pkg::OP_IMM_SUM: begin
                result = add_sum;
                write_acc = 1'b1;
                flags_nxt = '{add_cout, add_half,
                              is_zero(add_sum)};
            end
            exec_pkg::OP_FILE_SUM, exec_pkg::OP_FILE_SUM_C: begin
                result = add_sum;
                write_acc = !dest_file;
                write_file = dest_file;
                flags_nxt = '{add_cout, add_half,
                              is_zero(add_sum)};
            end
            exec_pkg::OP_IMM_MASK: begin
                result = acc_r & lit;
                write_acc = 1'b1;
                flags_nxt.zero = is_zero(result);
            end
            exec_pkg::OP_FILE_MASK: begin
                result = acc_r & file_rdata;
                write_acc = !dest_file;
                write_file = dest_file;
                flags_nxt.zero = is_zero(result);
            end
            exec_pkg::OP_SHIFT: begin
                result = {file_rdata[DATA_W-1], file_rdata[DATA_W-1:1]};
                write_acc = !dest_file;
                write_file = dest_file;
                flags_nxt.carry = file_rdata[0];
                flags_nxt.zero = is_zero(result);
            end
            exec_pkg::OP_BIT_CLR: begin
                // Read-modify-write of the whole byte; flags left alone
                result = file_rdata & ~(DATA_W'(1) << bit_idx);
                write_file = 1'b1;
            end
            default: begin
                result = '0;
            end
        endcase
        acc_nxt = write_acc ? result : acc_r;
        wr_nxt = '{write_file, faddr, result};
    end

    // State registers; file write is registered so it lands one cycle late
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            acc_r <= exec_pkg::ACC_RESET;
            flags_r <= '0;
            ptr0_r <= exec_pkg::PTR_RESET;
            ptr1_r <= exec_pkg::PTR_RESET;
            wr_r <= '0;
        end else begin
            acc_r <= acc_nxt;
            flags_r <= flags_nxt;
            ptr0_r <= ptr0_nxt;
            ptr1_r <= ptr1_nxt;
            wr_r <= wr_nxt;
        end
    end

    assign accum = acc_r;
    assign flags = flags_r;
    assign indirect_pointer_0 = ptr0_r;
    assign indirect_pointer_1 = ptr1_r;
    assign file_wr = wr_r;

    // Checks; each looks one edge after the op, against sampled operands
    chk_ptr_wrap: assert property (@(posedge clk)
        disable iff (reset)
        op == exec_pkg::OP_PTR_ADD && !opcode[exec_pkg::PTR_SEL_BIT]
        |=> ptr0_r == PTR_W'($past(ptr0_r) + $past(ptr_lit)))
        else $error("pointer 0 sum wrong");
    chk_ptr1_sum: assert property (@(posedge clk)
        disable iff (reset)
        op == exec_pkg::OP_PTR_ADD && opcode[exec_pkg::PTR_SEL_BIT]
        |=> ptr1_r == PTR_W'($past(ptr1_r) + $past(ptr_lit))
            && $stable(ptr0_r))
        else $error("pointer 1 sum wrong");
    chk_ptr_flags: assert property (@(posedge clk)
        disable iff (reset)
        op == exec_pkg::OP_PTR_ADD |=> $stable(flags_r))
        else $error("pointer add changed flags");
    chk_ptr_quiet: assert property (@(posedge clk)
        disable iff (reset)
        op == exec_pkg::OP_PTR_ADD |=> !wr_r.we && $stable(acc_r))
        else $error("pointer add touched data");
    chk_imm_sum: assert property (@(posedge clk)
        disable iff (reset)
        op == exec_pkg::OP_IMM_SUM
        |=> acc_r == DATA_W'($past(acc_r) + $past(lit)) && !wr_r.we)
        else $error("immediate sum wrong");
    chk_imm_decode: assert property (@(posedge clk)
        disable iff (reset)
        instr_valid
        && opcode[13:exec_pkg::TOP6_LSB] == exec_pkg::OPC_IMM_SUM
        |=> {flags_r.carry, acc_r} == 9'($past(acc_r))
            + 9'($past(opcode[DATA_W-1:0])))
        else $error("immediate sum decode wrong");
    chk_mask_decode: assert property (@(posedge clk)
        disable iff (reset)
        instr_valid
        && opcode[13:exec_pkg::TOP6_LSB] == exec_pkg::OPC_IMM_MASK
        |=> acc_r == ($past(acc_r) & $past(opcode[DATA_W-1:0]))
            && !wr_r.we)
        else $error("immediate mask decode wrong");
    chk_no_op: assert property (@(posedge clk)
        disable iff (reset)
        op == exec_pkg::OP_NONE
        |=> !wr_r.we && $stable(acc_r) && $stable(flags_r))
        else $error("idle cycle changed state");
    chk_dest_file: assert property (@(posedge clk)
        disable iff (reset)
        op == exec_pkg::OP_FILE_SUM && dest_file
        |=> wr_r.we && $stable(acc_r) && wr_r.addr == $past(faddr))
        else $error("destination select wrong");
    chk_dest_accum: assert property (@(posedge clk)
        disable iff (reset)
        (op == exec_pkg::OP_FILE_SUM || op == exec_pkg::OP_FILE_SUM_C)
        && !dest_file
        |=> !wr_r.we && acc_r == wr_r.data)
        else $error("accumulator destination wrong");
    chk_file_sum: assert property (@(posedge clk)
        disable iff (reset)
        op == exec_pkg::OP_FILE_SUM
        |=> {flags_r.carry, wr_r.data} == 9'($past(acc_r))
            + 9'($past(file_rdata)))
        else $error("file sum wrong");
    chk_sum_carry: assert property (@(posedge clk)
        disable iff (reset)
        op == exec_pkg::OP_FILE_SUM_C
        |=> {flags_r.carry, wr_r.data} == 9'($past(acc_r))
            + 9'($past(file_rdata)) + 9'($past(flags_r.carry)))
        else $error("carry sum wrong");
    chk_half_carry: assert property (@(posedge clk)
        disable iff (reset)
        op inside {exec_pkg::OP_IMM_SUM, exec_pkg::OP_FILE_SUM,
                   exec_pkg::OP_FILE_SUM_C}
        |=> flags_r.nibble_half_flag
            == |((DATA_W'($past(acc_r[exec_pkg::HALF_BIT-1:0]))
                  + DATA_W'($past(add_b[exec_pkg::HALF_BIT-1:0]))
                  + DATA_W'($past(add_cin))) >> exec_pkg::HALF_BIT))
        else $error("half carry wrong");
    chk_zero_flag: assert property (@(posedge clk)
        disable iff (reset)
        op inside {exec_pkg::OP_IMM_SUM, exec_pkg::OP_FILE_SUM,
                   exec_pkg::OP_FILE_SUM_C}
        |=> flags_r.zero == (wr_r.data == '0))
        else $error("sum zero flag wrong");
    chk_mask_zero: assert property (@(posedge clk)
        disable iff (reset)
        op == exec_pkg::OP_IMM_MASK
        |=> flags_r.carry == $past(flags_r.carry)
            && flags_r.zero == (acc_r == '0))
        else $error("mask flags wrong");
    chk_file_mask: assert property (@(posedge clk)
        disable iff (reset)
        op == exec_pkg::OP_FILE_MASK
        |=> wr_r.data == ($past(acc_r) & $past(file_rdata))
            && flags_r.zero == (wr_r.data == '0)
            && flags_r.carry == $past(flags_r.carry)
            && flags_r.nibble_half_flag
               == $past(flags_r.nibble_half_flag))
        else $error("file mask wrong");
    chk_shift_carry: assert property (@(posedge clk)
        disable iff (reset)
        op == exec_pkg::OP_SHIFT
        |=> flags_r.carry == $past(file_rdata[0])
            && wr_r.data[DATA_W-1] == $past(file_rdata[DATA_W-1]))
        else $error("shift wrong");
    chk_shift_body: assert property (@(posedge clk)
        disable iff (reset)
        op == exec_pkg::OP_SHIFT
        |=> wr_r.data[DATA_W-2:0] == $past(file_rdata[DATA_W-1:1])
            && flags_r.zero == (wr_r.data == '0))
        else $error("shift body wrong");
    chk_shift_dest: assert property (@(posedge clk)
        disable iff (reset)
        op == exec_pkg::OP_SHIFT
        |=> wr_r.we == $past(dest_file)
            && (wr_r.we ? $stable(acc_r) : acc_r == wr_r.data))
        else $error("shift destination wrong");
    chk_bit_clear: assert property (@(posedge clk)
        disable iff (reset)
        op == exec_pkg::OP_BIT_CLR
        |=> wr_r.we && wr_r.data[$past(bit_idx)] == 1'b0
            && $stable(flags_r))
        else $error("bit clear wrong");
    chk_clear_keep: assert property (@(posedge clk)
        disable iff (reset)
        op == exec_pkg::OP_BIT_CLR
        |=> (wr_r.data | (DATA_W'(1) << $past(bit_idx)))
            == ($past(file_rdata) | (DATA_W'(1) << $past(bit_idx)))
            && wr_r.addr == $past(faddr) && $stable(acc_r))
        else $error("bit clear touched other bits");
endmodule
`default_nettype wire

// ===== add_and_shift_bitclear_exec_tb.sv
// Self-checking testbench for the add, mask, shift and bit-clear datapath
`default_nettype none
module add_and_shift_bitclear_exec_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk, reset, instr_valid, we;
    logic [exec_pkg::OPC_W-1:0] opcode;
    logic [7:0] file_rdata, accum, acc, wd;
    logic [6:0] wa;
    exec_pkg::file_wr_t file_wr;
    exec_pkg::flags_t flags, fl;
    logic [15:0] indirect_pointer_0, indirect_pointer_1, p0, p1, rnd;
    logic [7:0] mem [128];
    int n_errors = 0;
    int samples_checked = 0;
    int ck [11] = '{0, 0, 0, 0, 1, 1, 4, 6, 7, 8, 9};
    logic [15:0] cr [11] = '{16'h0020, 16'h005F, 16'h001F, 16'h0001,
        16'h00FF, 16'h0001, 16'h00FF, 16'h0085, 16'h03FF, 16'h00FF,
        16'h0285};

    add_and_shift_bitclear_exec add_and_shift_bitclear_exec_i (
        .clk(clk), .reset(reset), .instr_valid(instr_valid),
        .opcode(opcode), .file_rdata(file_rdata), .file_wr(file_wr),
        .accum(accum), .flags(flags),
        .indirect_pointer_0(indirect_pointer_0),
        .indirect_pointer_1(indirect_pointer_1));

    // Clock at 20 MHz
    always #25 clk = ~clk;

    // Sixteen-bit pseudo-random sequence, repeatable from its seed
    function automatic logic [15:0] lfsr_next(input logic [15:0] v);
        return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
    endfunction

    // Expected sum as {carry out of bit 7, carry out of bit 3, sum}
    function automatic logic [9:0] sum_calc(input logic [7:0] a, b,
                                            input logic ci);
        logic [8:0] t;
        logic [4:0] h;
        t = {1'b0, a} + {1'b0, b} + {8'h00, ci};
        h = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, ci};
        return {t[8], h[4], t[7:0]};
    endfunction

    task automatic check(input string name, input logic [15:0] seen, exp);
        samples_checked++;
        if (seen !== exp) begin
            n_errors++;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic stop_test;
        $display("compares %0d mismatches %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    // Kinds: 0 pointer add, 1 imm sum, 2 imm mask, 3 file sum,
    // 4 sum with carry, 5 file mask, 6 shift, 7 bit clear,
    // 8 unknown opcode, 9 valid held low
    task automatic exec_op(input int kind, input logic [15:0] r);
        logic [13:0] op;
        logic [7:0] fv, res;
        logic [9:0] s;
        case (kind)
            0: op = {exec_pkg::OPC_PTR_ADD, r[6], r[5:0]};
            1: op = {exec_pkg::OPC_IMM_SUM, r[7:0]};
            2: op = {exec_pkg::OPC_IMM_MASK, r[7:0]};
            3: op = {exec_pkg::OPC_FILE_SUM, r[7:0]};
            4: op = {exec_pkg::OPC_FILE_SUM_C, r[7:0]};
            5: op = {exec_pkg::OPC_FILE_MASK, r[7:0]};
            6: op = {exec_pkg::OPC_SHIFT, r[7:0]};
            7: op = {exec_pkg::OPC_BIT_CLR, r[9:0]};
            8: op = {6'h3A, r[7:0]};
            default: op = {exec_pkg::OPC_IMM_SUM, r[7:0]};
        endcase
        fv = mem[op[6:0]];
        res = acc;
        // Reference behaviour; carry-in is the flag before this op
        case (kind)
            0: if (r[6]) p1 = p1 + {{10{r[5]}}, r[5:0]};
               else p0 = p0 + {{10{r[5]}}, r[5:0]};
            1, 3, 4: begin
                s = sum_calc(acc, kind == 1 ? r[7:0] : fv,
                             kind == 4 ? fl.carry : 1'b0);
                res = s[7:0];
                fl.carry = s[9];
                fl.nibble_half_flag = s[8];
            end
            2, 5: res = acc & (kind == 2 ? r[7:0] : fv);
            6: begin
                res = {fv[7], fv[7:1]};
                fl.carry = fv[0];
            end
            7: res = fv & ~(8'h01 << r[9:7]);
            default: ;
        endcase
        if (kind inside {[1:6]})
            fl.zero = (res == 8'h00);
        if (kind == 1 || kind == 2 || (kind inside {[3:6]} && !r[7]))
            acc = res;
        we = (kind == 7) || (kind inside {[3:6]} && r[7]);
        wa = op[6:0];
        wd = res;
        if (we)
            mem[wa] = res;
        opcode = op;
        file_rdata = fv;
        instr_valid = (kind != 9);
        @(posedge clk);
        #5;
        check("accum", 16'(accum), 16'(acc));
        check("flags", 16'(flags), 16'(fl));
        check("pointer0", indirect_pointer_0, p0);
        check("pointer1", indirect_pointer_1, p1);
        check("write_en", 16'(file_wr.we), 16'(we));
        if (we) begin
            check("write_addr", 16'(file_wr.addr), 16'(wa));
            check("write_data", 16'(file_wr.data), 16'(wd));
        end
    endtask

    // Watchdog sized well past the expected run of about 413 cycles
    initial begin
        #(50 * 5000);
        n_errors++;
        stop_test;
    end

    // Main sequence: reset, corner cases, then random instructions
    initial begin
        clk = 1'b0;
        reset = 1'b1;
        instr_valid = 1'b0;
        opcode = 14'h0000;
        file_rdata = 8'h00;
        acc = 8'h00;
        fl = 3'h0;
        p0 = 16'h0000;
        p1 = 16'h0000;
        rnd = 16'h0051;
        for (int i = 0; i < 128; i++) begin
            rnd = lfsr_next(rnd);
            mem[i] = rnd[7:0];
        end
        repeat (2) @(posedge clk);
        #5;
        reset = 1'b0;
        check("accum_rst", 16'(accum), 16'h0000);
        check("pointer_rst", indirect_pointer_0 | indirect_pointer_1,
              16'h0000);
        for (int i = 0; i < 11; i++)
            exec_op(ck[i], cr[i]);
        $display("corner tests done");
        for (int i = 0; i < 400; i++) begin
            rnd = lfsr_next(rnd);
            exec_op(int'(rnd[15:12]) % 10, rnd);
        end
        instr_valid = 1'b0;
        $display("random tests done");
        stop_test;
    end
endmodule
`default_nettype wire

// ===== exec_adder.sv
// Eight-bit adder with carry-in giving carry and half-carry
`default_nettype none
module exec_adder #(
    parameter int WIDTH = 8
) (
    // Operands
    input wire logic [WIDTH-1:0] a,
    input wire logic [WIDTH-1:0] b,
    input wire logic cin,
    // Results
    output logic [WIDTH-1:0] sum,
    output logic cout,
    output logic half
);
    logic [WIDTH:0] full;
    logic [exec_pkg::HALF_BIT:0] low;

    // Low nibble summed apart so its carry is visible
    always_comb begin
        full = {1'b0, a} + {1'b0, b} + {{WIDTH{1'b0}}, cin};
        low = {1'b0, a[exec_pkg::HALF_BIT-1:0]}
            + {1'b0, b[exec_pkg::HALF_BIT-1:0]}
            + {{exec_pkg::HALF_BIT{1'b0}}, cin};
        sum = full[WIDTH-1:0];
        cout = full[WIDTH];
        half = low[exec_pkg::HALF_BIT];
    end
endmodule
`default_nettype wire

// ===== exec_pkg.sv
// Package: opcode patterns, field layouts and carrier types for the datapath
`default_nettype none
package exec_pkg;
    localparam int OPC_W = 14;
    localparam int DATA_W = 8;
    localparam int ADDR_W = 7;
    localparam int PTR_W = 16;
    localparam int PTR_LIT_W = 6;
    // Upper six opcode bits of the immediate forms
    localparam logic [5:0] OPC_IMM_SUM = 6'h3E;
    localparam logic [5:0] OPC_IMM_MASK = 6'h39;
    // Upper six bits of register forms (dest in bit 7)
    localparam logic [5:0] OPC_FILE_SUM = 6'h07;
    localparam logic [5:0] OPC_FILE_SUM_C = 6'h3D;
    localparam logic [5:0] OPC_FILE_MASK = 6'h05;
    localparam logic [5:0] OPC_SHIFT = 6'h37;
    // Upper seven bits of pointer add, upper four of bit clear
    localparam logic [6:0] OPC_PTR_ADD = 7'h62;
    localparam logic [3:0] OPC_BIT_CLR = 4'h4;
    // Field positions in the opcode word
    localparam int TOP6_LSB = 8;
    localparam int TOP7_LSB = 7;
    localparam int TOP4_LSB = 10;
    localparam int DEST_BIT = 7;
    localparam int PTR_SEL_BIT = 6;
    localparam int BIT_IDX_LSB = 7;
    localparam int HALF_BIT = 4;
    localparam logic [7:0] ACC_RESET = 8'h00;
    localparam logic [15:0] PTR_RESET = 16'h0000;

    typedef enum logic [3:0] {
        OP_NONE, OP_PTR_ADD, OP_IMM_SUM, OP_FILE_SUM, OP_FILE_SUM_C,
        OP_IMM_MASK, OP_FILE_MASK, OP_SHIFT, OP_BIT_CLR
    } op_t;

    // Flags of the status word
    typedef struct packed {
        logic carry;
        logic nibble_half_flag;
        logic zero;
    } flags_t;

    // Request for a file register write
    typedef struct packed {
        logic we;
        logic [6:0] addr;
        logic [7:0] data;
    } file_wr_t;
endpackage
`default_nettype wire
